//--- pkg/pbs_cfg.svh
// Constants of the power button and standby sequencer
`ifndef PBS_CFG_SVH
`define PBS_CFG_SVH

// Clock period in ns (200 MHz)
`define PBS_CLK_NS 5
// Power switch hold threshold in ms
`define PBS_HOLD_MS 5000
// Hold threshold in clock cycles
`define PBS_HOLD_CYC 32'((64'(`PBS_HOLD_MS) * 64'd1000000) / 64'(`PBS_CLK_NS))
// Switch debounce time in us
`define PBS_DEB_US 10
// Debounce time in clock cycles
`define PBS_DEB_CYC 32'((`PBS_DEB_US * 1000) / `PBS_CLK_NS)

// Register byte offsets
`define PBS_OFS_CTRL 12'h000
`define PBS_OFS_TMO 12'h004
`define PBS_OFS_STAT 12'h008
`define PBS_OFS_IST 12'h00c
`define PBS_OFS_IMSK 12'h010

// Control fields
`define PBS_CTL_PM 0
`define PBS_CTL_ACPI 1
`define PBS_CTL_SUSP 2
`define PBS_CTL_STBY 3
// Control reset: power management on, legacy mode
`define PBS_CTRL_RST 32'h0000_0001
`define PBS_TMO_RST 32'h0000_0000

// Event bits of status and mask
`define PBS_NEV 7
`define PBS_EV_PRESS 0
`define PBS_EV_FORCE 1
`define PBS_EV_INTR 2
`define PBS_EV_SBIN 3
`define PBS_EV_SBOUT 4
`define PBS_EV_EXT 5
`define PBS_EV_LAN 6

`endif

//--- pkg/pbs_pkg.sv
// Types of the power button and standby sequencer
`include "pbs_cfg.svh"
package pbs_pkg;
  // System power state
  typedef enum logic [1:0] {
    st_off = 2'b00,
    st_on = 2'b01,
    st_sleep = 2'b10
  } pbs_pst_t;

  // APB request from the master
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pbs_apb_req_t;

  // APB answer to the master
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pbs_apb_rsp_t;

  // Debouncer state
  typedef struct packed {
    logic s1;
    logic s2;
    logic lvl;
    logic [31:0] cnt;
  } pbs_deb_t;

  // Sequencer state
  typedef struct packed {
    pbs_pst_t pst;
    logic stby;
    logic [31:0] cnt;
    logic prs_prev;
    logic slp_prev;
    logic intr_prev;
    logic lan_prev;
    logic [31:0] idle;
    logic ctl_pm;
    logic ctl_acpi;
    logic ctl_susp;
    logic [31:0] tmo;
    logic [`PBS_NEV-1:0] ist;
    logic [`PBS_NEV-1:0] msk;
    logic irq;
    logic alarm;
    logic pwr_en;
    logic sys_sleep;
    pbs_apb_rsp_t rsp;
  } pbs_st_t;
endpackage

//--- rtl/pbs_debounce.sv
// Two-stage synchroniser and debouncer for one switch input
`timescale 1ns/1ps
module pbs_debounce import pbs_pkg::*; #(
  parameter logic [31:0] CYC = `PBS_DEB_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Raw switch and clean level
  input wire logic raw,
  output logic lvl
);
  pbs_deb_t q;
  pbs_deb_t d;

  // Level changes only after CYC stable cycles
  always_comb begin
    d = q;
    d.s1 = raw;
    d.s2 = q.s1;
    if (q.s2 == q.lvl) begin
      d.cnt = 32'h0000_0000;
    end else if (q.cnt >= CYC - 32'h0000_0001) begin
      d.lvl = q.s2;
      d.cnt = 32'h0000_0000;
    end else begin
      d.cnt = q.cnt + 32'h0000_0001;
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lvl = q.lvl;
endmodule

//--- rtl/pbs_seq.sv
// Power button, standby and intrusion sequencer with APB registers
`timescale 1ns/1ps
module pbs_seq import pbs_pkg::*; #(
  parameter logic [31:0] HOLD_CYC = `PBS_HOLD_CYC,
  parameter logic [31:0] DEB_CYC = `PBS_DEB_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire pbs_apb_req_t apb_req,
  output pbs_apb_rsp_t apb_rsp,
  // Switches, active low while pressed or closed
  input wire logic pwr_sw_n,
  input wire logic sleep_sw_n,
  input wire logic intr_closed_n,
  // Activity and wake sources
  input wire logic kbd_act,
  input wire logic mouse_act,
  input wire logic ext_req,
  input wire logic lan_wake,
  // Power control outputs
  output logic pwr_en,
  output logic sys_sleep,
  output logic disk_down,
  output logic mon_off,
  output logic alarm,
  output logic irq
);
  pbs_st_t q;
  pbs_st_t d;
  logic prs; // Debounced power switch pressed
  logic slp; // Debounced sleep switch pressed
  logic intr; // Debounced cover open
  logic setup; // APB setup phase
  logic wr; // APB write completes
  logic short_rel; // Release before threshold
  logic long_hit; // Threshold crossed while held
  logic lan_go; // Network wake honoured
  logic act; // Keyboard or mouse activity
  logic sb_trig; // Any standby trigger
  logic [`PBS_NEV-1:0] ev; // Events of this cycle
  logic [`PBS_NEV-1:0] clr; // Write-one-to-clear mask
  // Control reset word; a literal cannot be bit-selected directly
  localparam logic [31:0] CTRL_RST = `PBS_CTRL_RST;

  // Register index of an address, 3'h7 when unmapped
  function automatic logic [2:0] reg_sel(input logic [11:0] a);
    case (a)
      `PBS_OFS_CTRL: reg_sel = 3'h0;
      `PBS_OFS_TMO: reg_sel = 3'h1;
      `PBS_OFS_STAT: reg_sel = 3'h2;
      `PBS_OFS_IST: reg_sel = 3'h3;
      `PBS_OFS_IMSK: reg_sel = 3'h4;
      default: reg_sel = 3'h7;
    endcase
  endfunction

  // Switch inputs cleaned before use; a press shorter than
  // the debounce time is never seen
  pbs_debounce #(.CYC(DEB_CYC)) u_pwr (
    .pclk(pclk),
    .presetn(presetn),
    .raw(~pwr_sw_n),
    .lvl(prs)
  );
  pbs_debounce #(.CYC(DEB_CYC)) u_slp (
    .pclk(pclk),
    .presetn(presetn),
    .raw(~sleep_sw_n),
    .lvl(slp)
  );
  // Open switch means cover removed
  pbs_debounce #(.CYC(DEB_CYC)) u_intr (
    .pclk(pclk),
    .presetn(presetn),
    .raw(intr_closed_n),
    .lvl(intr)
  );

  // Next-state logic
  always_comb begin
    d = q;
    ev = '0;
    clr = '0;
    setup = apb_req.psel & ~apb_req.penable;
    wr = apb_req.psel & apb_req.penable & q.rsp.pready & apb_req.pwrite;
    act = kbd_act | mouse_act;

    // Edge history of the clean switch inputs and of the raw network wake
    d.prs_prev = prs;
    d.slp_prev = slp;
    d.intr_prev = intr;
    d.lan_prev = lan_wake;

    // Press length counted in clock cycles, saturating
    if (prs) begin
      if (q.cnt != HOLD_CYC) begin
        d.cnt = q.cnt + 32'h0000_0001;
      end
    end else begin
      d.cnt = 32'h0000_0000;
    end
    short_rel = ~prs & q.prs_prev & (q.cnt < HOLD_CYC);
    // Fires while still held, no wait for release
    long_hit = prs & (q.cnt == HOLD_CYC - 32'h0000_0001);
    // Network wake ignored in the newer interface mode
    lan_go = lan_wake & ~q.lan_prev & ~q.ctl_acpi;

    if (short_rel) begin
      ev[`PBS_EV_PRESS] = 1'b1;
    end
    if (lan_go) begin
      ev[`PBS_EV_LAN] = 1'b1;
    end

    // Power state moves; in on and sleep a long press beats any other request
    case (q.pst)
      st_off: begin
        // Long press from off does nothing
        if (short_rel || lan_go) begin
          d.pst = st_on;
        end
      end
      st_on: begin
        if (long_hit) begin
          d.pst = st_off;
          ev[`PBS_EV_FORCE] = 1'b1;
        end else if (short_rel) begin
          // Suspend select picks sleep over soft off
          d.pst = q.ctl_susp ? st_sleep : st_off;
        end
      end
      st_sleep: begin
        if (long_hit) begin
          d.pst = st_off;
          ev[`PBS_EV_FORCE] = 1'b1;
        end else if (short_rel || lan_go) begin
          d.pst = st_on;
        end
      end
      default: begin
        d.pst = st_off;
      end
    endcase

    // Power outputs registered from the next state, no decode after flops
    d.pwr_en = d.pst != st_off;
    d.sys_sleep = d.pst == st_sleep;

    // Inactivity counter, restarted by any activity
    if (act || q.pst != st_on || q.stby) begin
      d.idle = 32'h0000_0000;
    end else if (q.idle != q.tmo) begin
      d.idle = q.idle + 32'h0000_0001;
    end

    // Standby triggers, all gated by the enable
    sb_trig = (q.tmo != 32'h0000_0000 && q.idle == q.tmo)
      | (slp & ~q.slp_prev)
      | (wr && reg_sel(apb_req.paddr) == 3'h0 && apb_req.pwdata[`PBS_CTL_STBY]);
    if (q.stby) begin
      if (act || d.pst != st_on) begin
        // Leave at once; monitor power back next cycle
        d.stby = 1'b0;
        ev[`PBS_EV_SBOUT] = 1'b1;
      end
    end else if (sb_trig && q.ctl_pm && !q.ctl_acpi && q.pst == st_on && d.pst == st_on) begin
      d.stby = 1'b1;
      ev[`PBS_EV_SBIN] = 1'b1;
    end

    // External requests latched in every state
    if (ext_req) begin
      ev[`PBS_EV_EXT] = 1'b1;
    end
    // Cover opening raises the alarm event
    if (intr && !q.intr_prev) begin
      ev[`PBS_EV_INTR] = 1'b1;
    end

    // Register writes at the completing access edge
    if (wr) begin
      case (reg_sel(apb_req.paddr))
        3'h0: begin
          d.ctl_pm = apb_req.pwdata[`PBS_CTL_PM];
          d.ctl_acpi = apb_req.pwdata[`PBS_CTL_ACPI];
          d.ctl_susp = apb_req.pwdata[`PBS_CTL_SUSP];
        end
        3'h1: begin
          d.tmo = apb_req.pwdata;
        end
        3'h3: begin
          clr = apb_req.pwdata[`PBS_NEV-1:0];
        end
        3'h4: begin
          d.msk = apb_req.pwdata[`PBS_NEV-1:0];
        end
        default: begin
          d.tmo = q.tmo;
        end
      endcase
    end

    // Sticky events; a new event wins over its clear
    d.ist = (q.ist & ~clr) | ev;
    d.irq = |(d.ist & d.msk);
    // Alarm sounds until software clears the event
    d.alarm = d.ist[`PBS_EV_INTR];

    // Answer prepared in setup, ready in the first access cycle
    d.rsp.pready = setup;
    d.rsp.pslverr = 1'b0;
    d.rsp.prdata = 32'h0000_0000;
    if (setup) begin
      case (reg_sel(apb_req.paddr))
        3'h0: begin
          d.rsp.prdata[`PBS_CTL_PM] = q.ctl_pm;
          d.rsp.prdata[`PBS_CTL_ACPI] = q.ctl_acpi;
          d.rsp.prdata[`PBS_CTL_SUSP] = q.ctl_susp;
        end
        3'h1: begin
          d.rsp.prdata = q.tmo;
        end
        3'h2: begin
          d.rsp.prdata[4:0] = {q.ctl_acpi, intr, q.stby, q.pst};
        end
        3'h3: begin
          d.rsp.prdata[`PBS_NEV-1:0] = q.ist;
        end
        3'h4: begin
          d.rsp.prdata[`PBS_NEV-1:0] = q.msk;
        end
        default: begin
          // Unmapped: error answer, data zero
          d.rsp.pslverr = 1'b1;
        end
      endcase
    end
  end

  // State register; legacy mode out of reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.ctl_pm <= CTRL_RST[`PBS_CTL_PM];
      q.ctl_acpi <= CTRL_RST[`PBS_CTL_ACPI];
      q.ctl_susp <= CTRL_RST[`PBS_CTL_SUSP];
      q.tmo <= `PBS_TMO_RST;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from the state flops
  assign apb_rsp = q.rsp;
  assign pwr_en = q.pwr_en;
  assign sys_sleep = q.sys_sleep;
  // Disks and monitor follow standby
  assign disk_down = q.stby;
  assign mon_off = q.stby;
  assign alarm = q.alarm;
  assign irq = q.irq;

  // Checks on the sequencing
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_short;
    !prs && q.prs_prev && q.cnt < HOLD_CYC;
  endsequence
  sequence s_long;
    prs && q.cnt == HOLD_CYC - 32'h0000_0001;
  endsequence

  a_off_short_on: assert property (
    (q.pst == st_off) ##0 s_short |=> q.pst == st_on)
    else $error("short press from off did not power on");
  a_on_short_down: assert property (
    (q.pst == st_on) ##0 s_short |=> q.pst != st_on
      && q.pst == ($past(q.ctl_susp) ? st_sleep : st_off))
    else $error("short press while working did not leave working");
  a_on_long_off: assert property (
    (q.pst == st_on) ##0 s_long |=> q.pst == st_off && q.ist[`PBS_EV_FORCE])
    else $error("long press while working did not force off");
  a_sleep_short_wake: assert property (
    (q.pst == st_sleep) ##0 s_short |=> q.pst == st_on)
    else $error("short press while sleeping did not wake");
  a_sleep_long_off: assert property (
    (q.pst == st_sleep) ##0 s_long |=> q.pst == st_off ##1 pwr_en == 1'b0)
    else $error("long press while sleeping did not power off");
  a_stby_gated: assert property (
    $rose(q.stby) |-> $past(q.ctl_pm) && !$past(q.ctl_acpi) && $past(q.pst) == st_on)
    else $error("standby entered while disabled or not working");
  a_stby_power: assert property (
    $rose(q.stby) |-> disk_down && mon_off && q.ist[`PBS_EV_SBIN])
    else $error("standby did not lower disk and monitor power");
  a_ext_kept: assert property (
    ext_req |=> q.ist[`PBS_EV_EXT] [*2])
    else $error("external request lost");
  a_act_wake: assert property (
    (q.stby && (kbd_act || mouse_act)) |=> !q.stby && !mon_off)
    else $error("activity did not leave standby at once");
  a_lan_acpi: assert property (
    (q.ctl_acpi && q.pst == st_off && !prs && !q.prs_prev) |=> q.pst == st_off)
    else $error("network wake honoured in newer mode");
  a_intr_alarm: assert property (
    (intr && !q.intr_prev) |=> ##1 alarm && irq == |(q.ist & q.msk))
    else $error("cover opening did not sound the alarm");
  a_apb_ready: assert property (
    (apb_req.psel && !apb_req.penable) |=> apb_rsp.pready ##1 !apb_rsp.pready)
    else $error("APB answer not one cycle after setup");
endmodule

//--- tb/pbs_panel.sv
// Front panel model: power switch, sleep switch and cover switch
`timescale 1ns/1ps
module pbs_panel (
  // Clock
  input wire logic pclk,
  // Contacts, low while pressed or closed
  output logic pwr_sw_n,
  output logic sleep_sw_n,
  output logic intr_closed_n
);
  // Released switches rest high; cover switch closed in normal use
  initial begin
    pwr_sw_n = 1'b1;
    sleep_sw_n = 1'b1;
    intr_closed_n = 1'b0;
  end

  // Press (0) or release (1); a press starts with a short bounce
  task automatic pw(input logic v);
    if (!v) begin
      @(posedge pclk) pwr_sw_n <= 1'b0;
      @(posedge pclk) pwr_sw_n <= 1'b1;
    end
    @(posedge pclk) pwr_sw_n <= v;
  endtask

  // Sleep switch level
  task automatic sl(input logic v);
    @(posedge pclk) sleep_sw_n <= v;
  endtask

  // Cover open (1) or closed (0); an open switch means intrusion
  task automatic cv(input logic v);
    @(posedge pclk) intr_closed_n <= v;
  endtask
endmodule

//--- tb/pbs_seq_bench.sv
// Self-checking bench of the power button and standby sequencer
`timescale 1ns/1ps
`include "pbs_cfg.svh"
module pbs_seq_bench import pbs_pkg::*;;
  // Clock, reset and bus
  logic pclk = 1'b0;
  logic presetn;
  pbs_apb_req_t req;
  pbs_apb_rsp_t rsp;
  // Activity strobes: lan, ext, mouse, kbd
  logic [3:0] act;
  logic pwr_sw_n, sleep_sw_n, intr_closed_n;
  logic pwr_en, sys_sleep, disk_down, mon_off, alarm, irq;
  // Last read answer
  logic [31:0] rdat;
  logic err;
  int error_cnt = 0;
  int n_checks = 0;

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // Short counts keep the run brief
  pbs_seq #(.HOLD_CYC(32'd200), .DEB_CYC(32'd4)) i_dut (
    .pclk(pclk), .presetn(presetn), .apb_req(req), .apb_rsp(rsp),
    .pwr_sw_n(pwr_sw_n), .sleep_sw_n(sleep_sw_n), .intr_closed_n(intr_closed_n),
    .kbd_act(act[0]), .mouse_act(act[1]), .ext_req(act[2]), .lan_wake(act[3]),
    .pwr_en(pwr_en), .sys_sleep(sys_sleep), .disk_down(disk_down),
    .mon_off(mon_off), .alarm(alarm), .irq(irq)
  );

  pbs_panel i_pan (
    .pclk(pclk), .pwr_sw_n(pwr_sw_n), .sleep_sw_n(sleep_sw_n),
    .intr_closed_n(intr_closed_n)
  );

  // Verdict and end of run
  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tk(input int n);
    repeat (n) @(posedge pclk);
  endtask

  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge pclk);
    req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    // A slave that never answers ends the run
    if (k >= 20) begin
      error_cnt++;
      test_done();
    end
    rdat = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Read and compare
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rdat, e);
  endtask

  // One-cycle activity strobe
  task automatic ps(input logic [3:0] m);
    @(posedge pclk);
    act <= m;
    @(posedge pclk);
    act <= 4'h0;
    tk(3);
  endtask

  // Press shorter than the hold limit, then state check
  task automatic pr(input int n, input logic [31:0] st);
    i_pan.pw(1'b0);
    tk(n);
    i_pan.pw(1'b1);
    tk(20);
    rc(`PBS_OFS_STAT, st);
    chk(pwr_en, st[1:0] != 2'b00);
  endtask

  // Press past the hold limit; power drops while still held
  task automatic lg();
    i_pan.pw(1'b0);
    tk(230);
    chk(pwr_en, 0);
    i_pan.pw(1'b1);
    tk(20);
    rc(`PBS_OFS_STAT, 32'h0);
  endtask

  // Sleep switch press
  task automatic sp();
    i_pan.sl(1'b0);
    tk(15);
    i_pan.sl(1'b1);
    tk(3);
  endtask

  // Main sequence
  initial begin
    // Bus idle and no activity while reset is held
    presetn <= 1'b0;
    req <= '0;
    act <= 4'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    rc(`PBS_OFS_CTRL, 32'h1);
    rc(`PBS_OFS_TMO, 32'h0);
    rc(`PBS_OFS_STAT, 32'h0);
    rc(`PBS_OFS_IST, 32'h0);
    rc(`PBS_OFS_IMSK, 32'h0);
    rc(12'h014, 32'h0);
    chk(err, 1);
    pr(30, 32'h1);
    rc(`PBS_OFS_IST, 32'h1);
    // Masked event keeps irq low
    wr(`PBS_OFS_IMSK, 32'h7e);
    tk(2);
    chk(irq, 0);
    wr(`PBS_OFS_IMSK, 32'h7f);
    tk(2);
    chk(irq, 1);
    wr(`PBS_OFS_IST, 32'h1);
    tk(2);
    chk(irq, 0);
    pr(30, 32'h0);
    pr(30, 32'h1);
    wr(`PBS_OFS_CTRL, 32'h5);
    pr(30, 32'h2);
    chk(sys_sleep, 1);
    pr(30, 32'h1);
    pr(30, 32'h2);
    lg();
    pr(30, 32'h1);
    // Standby by software request, left by activity
    wr(`PBS_OFS_CTRL, 32'h9);
    tk(2);
    chk({disk_down, mon_off}, 2'b11);
    ps(4'b0100);
    rc(`PBS_OFS_STAT, 32'h5);
    apb(1'b0, `PBS_OFS_IST, 32'h0);
    chk(rdat[5], 1);
    ps(4'b0001);
    chk({disk_down, mon_off}, 2'b00);
    sp();
    chk(disk_down, 1);
    ps(4'b0010);
    chk(mon_off, 0);
    wr(`PBS_OFS_TMO, 32'd40);
    tk(50);
    chk(disk_down, 1);
    wr(`PBS_OFS_TMO, 32'h0);
    ps(4'b0001);
    chk(disk_down, 0);
    // Power management off first; the request then finds it disabled
    wr(`PBS_OFS_CTRL, 32'h0);
    wr(`PBS_OFS_CTRL, 32'h8);
    tk(2);
    chk(disk_down, 0);
    sp();
    chk(disk_down, 0);
    wr(`PBS_OFS_CTRL, 32'h1);
    lg();
    apb(1'b0, `PBS_OFS_IST, 32'h0);
    chk(rdat[1], 1);
    wr(`PBS_OFS_IST, 32'h7f);
    // Network wake only in legacy mode
    wr(`PBS_OFS_CTRL, 32'h3);
    ps(4'b1000);
    rc(`PBS_OFS_STAT, 32'h10);
    wr(`PBS_OFS_CTRL, 32'h1);
    ps(4'b1000);
    rc(`PBS_OFS_STAT, 32'h1);
    // Cover opened: alarm until cleared
    i_pan.cv(1'b1);
    tk(20);
    chk(alarm, 1);
    rc(`PBS_OFS_STAT, 32'h9);
    i_pan.cv(1'b0);
    tk(20);
    chk(alarm, 1);
    wr(`PBS_OFS_IST, 32'h7f);
    tk(2);
    chk(alarm, 0);
    test_done();
  end
endmodule
